// ===== verilog/adst_pkg.sv
`default_nettype none
package adst_pkg;
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  ADDR_MODE   = 8'h00;
    localparam logic [7:0]  ADDR_STAT   = 8'h04;
    localparam logic [7:0]  ADDR_RES0   = 8'h20;
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    localparam int          CHAN_MSB    = 2;
    localparam int          FR_BIT      = 4;
    localparam int          MEL_BIT     = 5;
    localparam int          MEH_BIT     = 6;
    localparam int          TRG_BIT     = 7;
    localparam int          ST_BUSY_BIT = 0;
    localparam int          ST_WAIT_BIT = 1;
    localparam int          ST_IDX_LSB  = 4;
    localparam int          ST_BUF_LSB  = 8;
    localparam int          RES_W       = 10;
    localparam int          NUM_REG     = 8;
    localparam int          CONV_SLOW   = 208;
    localparam int          CONV_FAST   = 169;
    localparam logic [7:0]  CNT_SLOW    = 8'(CONV_SLOW - 1);
    localparam logic [7:0]  CNT_FAST    = 8'(CONV_FAST - 1);
    localparam logic [1:0]  BUF_LAST    = 2'h3;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_OFF  = 2'h0,
        OP_SEL1 = 2'h1,
        OP_SEL4 = 2'h2,
        OP_SCAN = 2'h3
    } adst_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_CONV = 3'h4
    } adst_state_t;

    function automatic adst_op_t mode_op(input logic [7:0] m);
        return adst_op_t'({m[MEH_BIT], m[MEL_BIT]});
    endfunction
endpackage
`default_nettype wire

// ===== verilog/adst_reg_if.sv
`default_nettype none
interface adst_reg_if;
    import adst_pkg::*;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_ok;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_ok;
    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   input wr_ok, rd_data, rd_ok);
    modport regs  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                   output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

// ===== verilog/adst_conv_timer.sv
`default_nettype none
module adst_conv_timer
    import adst_pkg::*;
(
    // Clock and reset.
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control.
    input  wire logic start,
    input  wire logic run,
    input  wire logic halt,
    input  wire logic fast,
    // Status.
    output logic      done
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] reload;
    logic [7:0] elapsed;
    logic [7:0] next_elapsed;

    assign reload = fast ? CNT_FAST : CNT_SLOW;
    assign done = run && !halt && !start && (cnt == 8'h00);

    always_comb begin
        next_cnt     = cnt;
        next_elapsed = elapsed;
        if (start || done) begin
            next_cnt     = reload;
            next_elapsed = 8'h00;
        end else if (run && !halt) begin
            next_cnt     = cnt - 8'h01;
            next_elapsed = elapsed + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt     <= CNT_SLOW;
            elapsed <= 8'h00;
        end else begin
            cnt     <= next_cnt;
            elapsed <= next_elapsed;
        end
    end

    property p_conv_len;
        @(posedge aclk) disable iff (!aresetn)
        done |-> elapsed == (fast ? CNT_FAST : CNT_SLOW);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("Conversion length wrong.");

    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        halt |-> !done ##1 $stable(cnt);
    endproperty
    a_halt: assert property (p_halt)
        else $error("Conversion advanced while halted.");
endmodule // adst_conv_timer
`default_nettype wire

// ===== verilog/adst_axil_slave.sv
`default_nettype none
module adst_axil_slave
    import adst_pkg::*;
(
    // Clock and reset.
    input  wire logic  aclk,
    input  wire logic  aresetn,
    // Write channels.
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // Read channels.
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Register side.
    adst_reg_if.slave        rif
);
    logic        aw_take;
    logic        ar_take;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;

    assign aw_take     = awvalid && wvalid && !bvalid;
    assign awready     = aw_take;
    assign wready      = aw_take;
    assign ar_take     = arvalid && !rvalid;
    assign arready     = !rvalid;
    assign rif.wr_en   = aw_take;
    assign rif.wr_addr = awaddr[ADDR_W-1:0];
    assign rif.wr_data = wdata;
    assign rif.wr_strb = wstrb;
    assign rif.rd_addr = araddr[ADDR_W-1:0];

    always_comb begin
        next_bvalid = bvalid;
        next_bresp  = bresp;
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_take) begin
            next_bvalid = 1'b1;
            next_bresp  = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (ar_take) begin
            next_rvalid = 1'b1;
            next_rresp  = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
            next_rdata  = rif.rd_ok ? rif.rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp  <= RESP_OKAY;
            rdata  <= 32'h0000_0000;
        end else begin
            bvalid <= next_bvalid;
            bresp  <= next_bresp;
            rvalid <= next_rvalid;
            rresp  <= next_rresp;
            rdata  <= next_rdata;
        end
    end

    property p_bus_answer;
        @(posedge aclk) disable iff (!aresetn)
        (aw_take |=> bvalid) and (ar_take |=> rvalid);
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Bus answer missing.");
endmodule // adst_axil_slave
`default_nettype wire

// ===== verilog/adst_ctrl.sv
// Notes on behaviour
// - Scan converts channels 0 up to selected one, result per index.
// - Scan raises end interrupt only after the whole series.
// - Mode write with trigger select 0 and an enable starts conversion.
// - Software rewrite during conversion aborts and restarts with new settings.
// - Conversions repeat back to back until mode is written again.
// - With trigger select 0 the trigger edge is ignored.
// - Select 1-buffer repeats one channel, interrupt after each conversion.
// - Select 4-buffer converts four times, interrupt per group of four.
// - After a scan series the scan restarts at channel 0.
// - Trigger select and enable set: standby until a trigger edge.
// - A further trigger edge aborts and restarts the sequence.
// - Rewrite with trigger select aborts and waits for an edge again.
// - After a hardware start conversions continue without new edges.
// - Clearing both mode enables stops conversion.
// - Low power state halts conversion; comparator powered while enabled.
// - Conversion lasts 208 clocks, or 169 with fast rate selected.
// - Mode enables sit at bits 5 and 6 of the mode register.
// - Channel select occupies bits 0 to 2 of the mode register.
// - Results are 10 bits, upper word bits read zero.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module adst_ctrl
    import adst_pkg::*;
(
    // Clock and reset.
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write channels.
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read channels.
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Trigger, power and channel group.
    input  wire logic        ext_trigger_pin,
    input  wire logic        low_power_halt,
    input  wire logic        chan_group,
    // Converter side.
    input  wire logic [9:0]  sample_data,
    output logic [3:0]       analog_sel,
    output logic             comparator_pwr,
    output logic             conv_end_irq
);
    adst_reg_if rif ();

    logic [7:0]       mode;
    logic [7:0]       next_mode;
    adst_state_t      state;
    adst_state_t      next_state;
    logic [2:0]       idx;
    logic [2:0]       next_idx;
    logic [1:0]       bidx;
    logic [1:0]       next_bidx;
    logic             next_irq;
    logic [3:0]       next_sel;
    logic             restart;
    logic             store;
    logic             done;
    logic             mode_wr;
    logic             trig_hit;
    adst_op_t         op;
    adst_op_t         wr_op;
    logic [2:0]       chan;
    logic [2:0]       res_idx;
    logic [RES_W-1:0] result [NUM_REG];
    logic [31:0]      status;
    logic             fast_now;

    adst_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif)
    );

    adst_conv_timer u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (restart),
        .run     (state == ST_CONV),
        .halt    (low_power_halt),
        .fast    (fast_now),
        .done    (done)
    );

    assign op    = mode_op(mode);
    assign wr_op = mode_op(rif.wr_data[7:0]);
    assign chan  = mode[CHAN_MSB:0];
    assign comparator_pwr = (op != OP_OFF);
    // A restart loads the newly written rate.
    assign fast_now = restart ? next_mode[FR_BIT] : mode[FR_BIT];

    assign rif.wr_ok = (rif.wr_addr == ADDR_MODE);
    assign mode_wr   = rif.wr_en && rif.wr_ok && rif.wr_strb[0];
    // Trigger pulse, gated by trigger select.
    assign trig_hit  = ext_trigger_pin && mode[TRG_BIT]
                       && (state != ST_IDLE);

    always_comb begin
        unique case (op)
            OP_SEL4: res_idx = {chan[CHAN_MSB], bidx};
            OP_SCAN: res_idx = idx;
            default: res_idx = chan;
        endcase
    end

    always_comb begin
        next_mode  = mode;
        next_state = state;
        next_idx   = idx;
        next_bidx  = bidx;
        next_irq   = 1'b0;
        restart    = 1'b0;
        store      = 1'b0;
        if (mode_wr) begin
            next_mode = rif.wr_data[7:0];
            next_idx  = 3'h0;
            next_bidx = 2'h0;
            if (wr_op == OP_OFF) begin
                next_state = ST_IDLE;
            end else if (rif.wr_data[TRG_BIT]) begin
                next_state = ST_WAIT;
            end else begin
                next_state = ST_CONV;
                restart    = 1'b1;
            end
        end else if (trig_hit) begin
            next_state = ST_CONV;
            next_idx   = 3'h0;
            next_bidx  = 2'h0;
            restart    = 1'b1;
        // Back to back, no new edge needed.
        end else if (state == ST_CONV && done) begin
            store = 1'b1;
            unique case (op)
                OP_SEL1: next_irq = 1'b1;
                OP_SEL4: begin
                    next_bidx = bidx + 2'h1;
                    next_irq  = (bidx == BUF_LAST);
                end
                // Series end, wrap to channel 0.
                OP_SCAN: begin
                    next_idx = (idx == chan) ? 3'h0 : idx + 3'h1;
                    next_irq = (idx == chan);
                end
                OP_OFF: next_irq = 1'b0;
            endcase
        end
    end

    // Channel group selects n or n+8.
    always_comb begin
        next_sel = {chan_group, mode_op(next_mode) == OP_SCAN ?
                    next_idx : next_mode[CHAN_MSB:0]};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode         <= MODE_RESET;
            state        <= ST_IDLE;
            idx          <= 3'h0;
            bidx         <= 2'h0;
            conv_end_irq <= 1'b0;
            analog_sel   <= 4'h0;
        end else begin
            mode         <= next_mode;
            state        <= next_state;
            idx          <= next_idx;
            bidx         <= next_bidx;
            conv_end_irq <= next_irq;
            analog_sel   <= next_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (store) begin
            result[res_idx] <= sample_data;
        end
    end

    assign status = 32'(state == ST_CONV) << ST_BUSY_BIT
                  | 32'(state == ST_WAIT) << ST_WAIT_BIT
                  | 32'(idx) << ST_IDX_LSB
                  | 32'(bidx) << ST_BUF_LSB;

    // Read mux with zero upper bits.
    always_comb begin
        rif.rd_ok   = 1'b1;
        rif.rd_data = 32'h0000_0000;
        if (rif.rd_addr == ADDR_MODE) begin
            rif.rd_data = {24'h00_0000, mode};
        end else if (rif.rd_addr == ADDR_STAT) begin
            rif.rd_data = status;
        end else if (rif.rd_addr[7:5] == ADDR_RES0[7:5]
                     && rif.rd_addr[1:0] == 2'h0) begin
            rif.rd_data = {22'h00_0000, result[rif.rd_addr[4:2]]};
        end else begin
            rif.rd_ok = 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_sw_start;
        mode_wr && wr_op != OP_OFF && !rif.wr_data[TRG_BIT]
            |-> restart ##1 (state == ST_CONV && idx == 3'h0);
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("Software start missing.");

    property p_hw_wait;
        mode_wr && wr_op != OP_OFF && rif.wr_data[TRG_BIT]
            |=> state == ST_WAIT && !conv_end_irq;
    endproperty
    a_hw_wait: assert property (p_hw_wait)
        else $error("Standby not entered.");

    property p_trg_ignored;
        !mode[TRG_BIT] && !mode_wr |-> !restart;
    endproperty
    a_trg_ignored: assert property (p_trg_ignored)
        else $error("Trigger acted while disabled.");

    property p_trg_restart;
        ext_trigger_pin && mode[TRG_BIT] && state != ST_IDLE && !mode_wr
            |=> state == ST_CONV && idx == 3'h0 && bidx == 2'h0;
    endproperty
    a_trg_restart: assert property (p_trg_restart)
        else $error("Trigger restart missing.");

    property p_stop;
        mode_wr && wr_op == OP_OFF |=> state == ST_IDLE ##1 !conv_end_irq;
    endproperty
    a_stop: assert property (p_stop)
        else $error("Conversion did not stop.");

    property p_sel1_irq;
        store && op == OP_SEL1 |=> conv_end_irq ##1 !conv_end_irq;
    endproperty
    a_sel1_irq: assert property (p_sel1_irq)
        else $error("Select 1 interrupt wrong.");

    property p_sel4_irq;
        store && op == OP_SEL4 |=> conv_end_irq == ($past(bidx) == BUF_LAST);
    endproperty
    a_sel4_irq: assert property (p_sel4_irq)
        else $error("Select 4 interrupt wrong.");

    property p_scan_step;
        store && op == OP_SCAN && idx != chan
            |=> idx == $past(idx) + 3'h1 && !conv_end_irq;
    endproperty
    a_scan_step: assert property (p_scan_step)
        else $error("Scan step wrong.");

    property p_scan_wrap;
        store && op == OP_SCAN && idx == chan |=> idx == 3'h0 && conv_end_irq;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap)
        else $error("Scan wrap wrong.");

    property p_continue;
        store && !mode_wr |=> state == ST_CONV;
    endproperty
    a_continue: assert property (p_continue)
        else $error("Conversion did not continue.");

    property p_rewrite_wait;
        mode_wr && state == ST_CONV && wr_op != OP_OFF
            && rif.wr_data[TRG_BIT]
            |=> state == ST_WAIT && idx == 3'h0 && bidx == 2'h0;
    endproperty
    a_rewrite_wait: assert property (p_rewrite_wait)
        else $error("Rewrite did not return to standby.");

    property p_enable_bits;
        mode_wr |=> comparator_pwr == ($past(rif.wr_data[MEH_BIT])
                                       || $past(rif.wr_data[MEL_BIT]));
    endproperty
    a_enable_bits: assert property (p_enable_bits)
        else $error("Enable bits misplaced.");

    property p_sel_out;
        mode_wr && wr_op != OP_SCAN
            |=> analog_sel == {$past(chan_group), mode[CHAN_MSB:0]};
    endproperty
    a_sel_out: assert property (p_sel_out)
        else $error("Analog select wrong.");

    property p_scan_store;
        store && op == OP_SCAN
            |-> res_idx == idx && analog_sel[CHAN_MSB:0] == idx;
    endproperty
    a_scan_store: assert property (p_scan_store)
        else $error("Scan result placed wrong.");

    property p_read_zero;
        arvalid && arready |=> rdata[31:RES_W] == 22'h00_0000;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("Upper read bits not zero.");
endmodule // adst_ctrl
`default_nettype wire

// ===== dv/adst_conv_model.sv
`default_nettype none
module adst_conv_model (
    // Clock.
    input  wire logic       aclk,
    // Bench control.
    input  wire logic       fire,
    input  wire logic [5:0] salt,
    // Converter side.
    input  wire logic [3:0] analog_sel,
    output logic      [9:0] sample_data,
    output logic            ext_trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge aclk) begin
        ext_trigger_pin <= fire;
    end
    // The level follows the selected channel.
    assign sample_data = {analog_sel, salt};
endmodule // adst_conv_model
`default_nettype wire

// ===== dv/adst_ctrl_tb.sv
`default_nettype none
module adst_ctrl_tb import adst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, low_power_halt = 0, chan_group = 0, fire = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        ext_trigger_pin, comparator_pwr, conv_end_irq;
    logic [3:0]  wstrb = '0, analog_sel;
    logic [1:0]  bresp, rresp;
    logic [9:0]  sample_data;
    logic [5:0]  salt = '0;
    int          err_count = 0, checked = 0, seed = 32'h3b46;

    always #10 aclk = ~aclk;

    adst_ctrl adst_ctrl_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_trigger_pin(ext_trigger_pin), .low_power_halt(low_power_halt),
        .chan_group(chan_group), .sample_data(sample_data),
        .analog_sel(analog_sel), .comparator_pwr(comparator_pwr),
        .conv_end_irq(conv_end_irq)
    );
    adst_conv_model adst_conv_model_inst (
        .aclk(aclk), .fire(fire), .salt(salt), .analog_sel(analog_sel),
        .sample_data(sample_data), .ext_trigger_pin(ext_trigger_pin)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string w, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", w, exp, seen);
        end
    endtask

    function automatic int per(input logic f);
        return f ? CONV_FAST : CONV_SLOW;
    endfunction

    function automatic int win(input int n, input int e);
        return (n >= e - 3 && n <= e + 3) ? e : n;
    endfunction

    function automatic logic [31:0] mval(input logic g,
        input logic [1:0] op, input logic f, input logic [2:0] c);
        return {24'h0, g, op, f, 1'b0, c};
    endfunction

    task automatic await(input int w);
        int n;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            if (w == 0 && awready === 1'b1) return;
            if (w == 1 && bvalid === 1'b1) return;
            if (w == 2 && arready === 1'b1) return;
            if (w == 3 && rvalid === 1'b1) return;
        end
        err_count++;
        $display("BAD handshake exp 1 seen timeout");
        wrap_up();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= {24'h0, a};
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        await(0);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        await(1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic rchk(input string w, input logic [7:0] a,
                        input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr  <= {24'h0, a};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        await(2);
        @(posedge aclk);
        arvalid <= 1'b0;
        await(3);
        check(w, rdata, e);
        check(w, {30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wirq(input int lim, output int n);
        for (n = 1; n <= lim; n++) begin
            @(negedge aclk);
            if (conv_end_irq === 1'b1) begin
                @(posedge aclk);
                return;
            end
        end
    endtask

    task automatic pulse();
        @(posedge aclk);
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
    endtask

    task automatic run_sw(input adst_op_t op, input logic [2:0] c,
                          input logic f);
        int n, k, t;
        logic [1:0] r;
        logic [2:0] ix, ch;
        t = per(f);
        k = (op == OP_SEL1) ? 1 : (op == OP_SEL4) ? 4 : int'(c) + 1;
        salt <= 6'($random(seed));
        chan_group <= 1'($random(seed));
        // Mode is written before waiting for any interrupt.
        wr(ADDR_MODE, mval(1'b0, op, f, c), r);
        check("mode resp", {30'h0, r}, {30'h0, RESP_OKAY});
        wirq(k * t + 9, n);
        check("first irq", win(n, k * t), k * t);
        wirq(k * t + 9, n);
        check("irq gap", n, k * t);
        check("pwr on", {31'h0, comparator_pwr}, 32'h1);
        if (op == OP_SEL1)
            check("sel", 32'(analog_sel), 32'({chan_group, c}));
        rchk("mode rd", ADDR_MODE, mval(1'b0, op, f, c),
             RESP_OKAY);
        for (int j = 0; j < k; j++) begin
            ch = (op == OP_SCAN) ? 3'(j) : c;
            ix = (op == OP_SEL4) ? {c[2], 2'(j)} : ch;
            rchk("result", 8'(ADDR_RES0 + 4 * ix),
                 {22'h0, chan_group, ch, salt}, RESP_OKAY);
        end
        $display("done op %0d chan %0d fast %0d", op, c, f);
    endtask

    initial begin
        int n;
        logic [31:0] d;
        logic [1:0] r;
        logic [2:0] c;
        logic f;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("mode rst", ADDR_MODE, 32'h0, RESP_OKAY);
        check("pwr rst", {31'h0, comparator_pwr}, 32'h0);
        rchk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
        wr(ADDR_STAT, 32'h1, r);
        check("ro wr", {30'h0, r}, {30'h0, RESP_SLVERR});
        $display("done reset");
        for (int i = 0; i < 7; i++) begin
            repeat (50 + ($random(seed) & 127)) @(posedge aclk);
            c = 3'($random(seed));
            f = 1'($random(seed));
            if (i == 0) run_sw(OP_SCAN, 3'h7, 1'b0);
            else if (i == 1) run_sw(OP_SCAN, 3'h0, 1'b1);
            else run_sw(adst_op_t'(2'(i % 3 + 1)), c, f);
        end
        wirq(300, n);
        repeat (50) @(posedge aclk);
        pulse();
        wirq(300, n);
        check("trig off", win(n + 53, per(f)), per(f));
        repeat (20) @(posedge aclk);
        low_power_halt <= 1'b1;
        repeat (100) @(posedge aclk);
        check("pwr halt", {31'h0, comparator_pwr}, 32'h1);
        low_power_halt <= 1'b0;
        wirq(400, n);
        check("halt", win(n + 120, per(f) + 100), per(f) + 100);
        $display("done sw trigger and halt");
        wr(ADDR_MODE, mval(1'b1, OP_SEL4, 1'b0, 3'h5), r);
        wirq(300, n);
        check("standby", n, 301);
        rchk("wait bit", ADDR_STAT, 32'h2, RESP_OKAY);
        pulse();
        wirq(900, n);
        check("hw start", win(n, 4 * CONV_SLOW), 4 * CONV_SLOW);
        wirq(900, n);
        check("hw repeat", n, 4 * CONV_SLOW);
        check("sel4", 32'(analog_sel), 32'({chan_group, 3'h5}));
        repeat (300) @(posedge aclk);
        pulse();
        wirq(900, n);
        check("retrig", win(n, 4 * CONV_SLOW), 4 * CONV_SLOW);
        repeat (100) @(posedge aclk);
        wr(ADDR_MODE, mval(1'b1, OP_SCAN, 1'b1, 3'h3), r);
        wirq(600, n);
        check("rewrite", n, 601);
        pulse();
        wirq(800, n);
        check("scan hw", win(n, 4 * CONV_FAST), 4 * CONV_FAST);
        $display("done hw trigger");
        wr(ADDR_MODE, 32'h0, r);
        wirq(300, n);
        check("stopped", n, 301);
        check("pwr off", {31'h0, comparator_pwr}, 32'h0);
        // Enables cleared before the low power state.
        @(posedge aclk);
        low_power_halt <= 1'b1;
        repeat (20) @(posedge aclk);
        check("pwr sleep", {31'h0, comparator_pwr}, 32'h0);
        low_power_halt <= 1'b0;
        $display("done stop");
        run_sw(OP_SEL1, 3'h2, 1'b1);
        wrap_up();
    end
endmodule // adst_ctrl_tb
`default_nettype wire
